// File: hdl/kplif_top.sv
// Keypad line flags, enables and level select with interrupt request
//
// Overview of operation
// - Each line sets its own flag whenever it shows its selected level.
// - Interrupt request comes only from flags whose enable bit is one.
// - Flag register at 9Eh is read-only; a read returns all flags and clears those whose line no longer shows its level.
// - Enable bit zero leaves the pin plain I/O; its flag still sets but requests no interrupt or wake.
// - Enable bit one lets the same-numbered flag request an interrupt.
// - Reset clears all flags and all enables.
// - Level select zero detects low level, one detects high level.
// - Global keypad enable gates the combined request before the CPU.
// - Eight lines are independent sources combined onto one vector.
// - Qualifying level on enabled line wakes from idle and power-down.
`timescale 1ns/1ns
`include "kplif_defines.svh"

// Two-flop synchroniser for inputs from outside the clock domain
module kplif_sync2 #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Reset to the idle level of the input, else a false match follows reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  // Only the second stage leaves this module
  assign sync_out = sync_ff;

endmodule // kplif_sync2

// One keypad line: level match, sticky flag and its enable bit
module kplif_line_cell (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pin_sync,
  input  wire logic level_sel,
  input  wire logic flag_clear,
  input  wire logic enable_load,
  input  wire logic enable_wdata,
  output var  logic line_hit,
  output var  logic flag_q,
  output var  logic enable_q,
  output var  logic nxt_flag,
  output var  logic nxt_enable
);
  logic flag_ff;
  logic enable_ff;
  logic flag_kept;

  // Zero selects a low level, one a high level
  assign line_hit = ~(pin_sync ^ level_sel);

  // Writes never reach the flag; only reset or a read of the flag register clears it
  assign flag_kept = flag_ff & ~flag_clear;

  // Set wins over clear so a key still held during the read is not lost
  assign nxt_flag = flag_kept | line_hit;

  // Enable zero keeps the pin plain I/O; one lets the flag request
  assign nxt_enable = enable_load ? enable_wdata : enable_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_ff <= `KPLIF_RESET_FLAG_BIT;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enable_ff <= `KPLIF_RESET_ENABLE_BIT;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  assign flag_q   = flag_ff;
  assign enable_q = enable_ff;

endmodule // kplif_line_cell

module kplif_top (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire kplif_pkg::kplif_byte_type port_one_pins,
  input  wire kplif_pkg::kplif_addr_type sfr_addr,
  input  wire kplif_pkg::kplif_byte_type sfr_wdata,
  input  wire logic                      sfr_wr,
  input  wire logic                      sfr_rd,
  input  wire logic                      keypad_global_irq_enable,
  output var  kplif_pkg::kplif_byte_type sfr_rdata,
  output var  logic                      keypad_irq_req,
  output var  logic                      keypad_wake_req,
  output var  kplif_pkg::kplif_byte_type keypad_line_enables,
  output var  kplif_pkg::kplif_byte_type keypad_line_flags
);
  import kplif_pkg::*;

  kplif_byte_type pin_sync;
  logic           glob_sync;
  kplif_byte_type level_sel_ff;
  kplif_byte_type rdata_ff;
  logic           irq_ff;
  logic           wake_ff;

  kplif_byte_type line_hit;
  kplif_byte_type flag_q;
  kplif_byte_type enable_q;
  kplif_byte_type nxt_flags;
  kplif_byte_type nxt_enables;
  kplif_byte_type nxt_levels;
  kplif_byte_type nxt_rdata;
  logic           sel_lvl;
  logic           sel_en;
  logic           sel_flg;
  logic           wr_lvl;
  logic           wr_en;
  logic           flag_read;
  logic           nxt_irq;
  logic           nxt_wake;

  // Idle pins sit high on their pull-ups, so the pin stage resets high
  kplif_sync2 #(
    .WIDTH     (`KPLIF_LINES),
    .RESET_VAL (`KPLIF_PIN_IDLE)
  ) u_kplif_sync2_pins (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (port_one_pins),
    .sync_out (pin_sync)
  );

  // The global gate is a bit of another register, treated as asynchronous
  kplif_sync2 #(
    .WIDTH     (1),
    .RESET_VAL (`KPLIF_RESET_GLOBAL)
  ) u_kplif_sync2_global (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (keypad_global_irq_enable),
    .sync_out (glob_sync)
  );

  assign sel_lvl   = (sfr_addr == `KPLIF_ADDR_LEVEL_SELECT);
  assign sel_en    = (sfr_addr == `KPLIF_ADDR_LINE_ENABLES);
  assign sel_flg   = (sfr_addr == `KPLIF_ADDR_LINE_FLAGS);
  assign wr_lvl    = sfr_wr && sel_lvl;
  assign wr_en     = sfr_wr && sel_en;
  // Every read strobe at the flag address clears, even back to back
  assign flag_read = sfr_rd && sel_flg;

  // Each line is its own source with its own flag and enable
  genvar line_idx;
  generate
    for (line_idx = 0; line_idx < `KPLIF_LINES; line_idx++) begin : g_line
      kplif_line_cell u_kplif_line_cell (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .pin_sync     (pin_sync[line_idx]),
        .level_sel    (level_sel_ff[line_idx]),
        .flag_clear   (flag_read),
        .enable_load  (wr_en),
        .enable_wdata (sfr_wdata[line_idx]),
        .line_hit     (line_hit[line_idx]),
        .flag_q       (flag_q[line_idx]),
        .enable_q     (enable_q[line_idx]),
        .nxt_flag     (nxt_flags[line_idx]),
        .nxt_enable   (nxt_enables[line_idx])
      );
    end
  endgenerate

  assign nxt_levels = wr_lvl ? sfr_wdata : level_sel_ff;

  // Read data follows the address every cycle, not only on read strobes
  assign nxt_rdata = sel_flg ? flag_q :
                     sel_en  ? enable_q :
                     sel_lvl ? level_sel_ff : `KPLIF_UNMAPPED_DATA;

  // Flags without enable stay visible but request nothing
  assign nxt_irq  = glob_sync && |(nxt_flags & nxt_enables);
  // Wake ignores the global gate so power-down exit never depends on it
  assign nxt_wake = |(line_hit & enable_q);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      level_sel_ff <= `KPLIF_RESET_LEVELS;
    end else begin
      level_sel_ff <= nxt_levels;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= `KPLIF_RESET_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= `KPLIF_RESET_REQ;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wake_ff <= `KPLIF_RESET_REQ;
    end else begin
      wake_ff <= nxt_wake;
    end
  end

  assign sfr_rdata           = rdata_ff;
  assign keypad_irq_req      = irq_ff;
  assign keypad_wake_req     = wake_ff;
  assign keypad_line_enables = enable_q;
  assign keypad_line_flags   = flag_q;

endmodule // kplif_top

// File: hdl/kplif_defines.svh
// Register offsets, reset values and widths of the keypad line interrupt block
`ifndef KPLIF_DEFINES_SVH
`define KPLIF_DEFINES_SVH
`define KPLIF_ADDR_LEVEL_SELECT 8'h9c
`define KPLIF_ADDR_LINE_ENABLES 8'h9d
`define KPLIF_ADDR_LINE_FLAGS   8'h9e
`define KPLIF_LINES             8
`define KPLIF_RESET_ENABLES     8'h00
`define KPLIF_RESET_FLAGS       8'h00
`define KPLIF_RESET_LEVELS      8'h00
`define KPLIF_RESET_FLAG_BIT    1'b0
`define KPLIF_RESET_ENABLE_BIT  1'b0
`define KPLIF_RESET_RDATA       8'h00
`define KPLIF_RESET_REQ         1'b0
`define KPLIF_RESET_GLOBAL      1'b0
`define KPLIF_PIN_IDLE          8'hff
`define KPLIF_UNMAPPED_DATA     8'h00
`endif

// File: hdl/kplif_pkg.sv
// Types shared by the keypad line interrupt block
package kplif_pkg;
  typedef logic [7:0] kplif_byte_type;
  typedef logic [7:0] kplif_addr_type;
endpackage

// File: sim/kplif_props.sv
// Checker for the keypad line interrupt block
`timescale 1ns/1ns
module kplif_props (input wire logic clk_sys, sys_rst, sfr_rd, sfr_wr, keypad_irq_req,
  input wire logic keypad_wake_req, keypad_global_irq_enable,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, keypad_line_enables, keypad_line_flags);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire rc = sfr_rd && sfr_addr == 8'h9e;
  rd_data_a: assert property (rc |=> sfr_rdata == $past(keypad_line_flags))
    else $error("flag read");
  flag_sticky_a: assert property (!rc |=> ($past(keypad_line_flags) & ~keypad_line_flags) == 0)
    else $error("flag lost");
  en_wr_a: assert property (sfr_wr && sfr_addr == 8'h9d |=> keypad_line_enables == $past(sfr_wdata))
    else $error("enable write");
  irq_mask_a: assert property (keypad_irq_req |-> |(keypad_line_flags & keypad_line_enables))
    else $error("irq mask");
  irq_gate_a: assert property (keypad_irq_req |-> $past(keypad_global_irq_enable, 3))
    else $error("irq without global enable");
  wake_gate_a: assert property (keypad_wake_req |-> $past(keypad_line_enables) != 8'h00)
    else $error("wake without enable");
  en_hold_a: assert property (!(sfr_wr && sfr_addr == 8'h9d) |=> $stable(keypad_line_enables))
    else $error("enable changed");
  cover property (keypad_wake_req);
  cover property (keypad_irq_req);
  cover property (rc && keypad_line_flags != 0);
endmodule // kplif_props
bind kplif_top kplif_props u_kplif_props (.*);

// File: sim/kplif_keypad.sv
// Key matrix model on the eight port lines
`timescale 1ns/1ns
module kplif_keypad (input wire logic [7:0] keys, output wire logic [7:0] pins);
  assign pins = ~keys; // Pull-ups hold released lines high
endmodule // kplif_keypad

// File: sim/kplif_top_bench.sv
// Self-checking bench for the keypad line interrupt block
`timescale 1ns/1ns
module kplif_top_bench;
  logic c = 1'b0, sys_rst = 1'b1, w = 1'b0, r = 1'b0, g = 1'b0, irq, wk;
  logic [7:0] a = 8'h00, d = 8'h00, k = 8'h00, p, q, e, f;
  int miscompares = 0, check_count = 0;
  always #50 c = ~c;
  kplif_keypad u_kplif_keypad (.keys(k), .pins(p));
  kplif_top u_kplif_top (.clk_sys(c), .sys_rst, .port_one_pins(p), .sfr_addr(a), .sfr_wdata(d),
    .sfr_wr(w), .sfr_rd(r), .keypad_global_irq_enable(g), .sfr_rdata(q), .keypad_irq_req(irq),
    .keypad_wake_req(wk), .keypad_line_enables(e), .keypad_line_flags(f));
  task automatic chk(input logic [7:0] x, y);
    check_count++;
    miscompares += (x !== y);
    if (x !== y) $display("ERROR %0t got %h exp %h", $time, x, y);
  endtask
  // Read checks y against the returned byte; write sends y
  task automatic io(input logic [7:0] x, y, input logic v);
    @(negedge c) {a, d, w, r} = {x, y, v, !v};
    @(negedge c) {w, r} = 2'b00;
    if (!v) chk(q, y);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge c);
    sys_rst = 1'b0;
    io(8'h9d, 8'h00, 1'b0);
    io(8'h9e, 8'h00, 1'b0);
    io(8'h9e, 8'hff, 1'b1);
    chk(f, 8'h00);
    io(8'h9d, 8'h10, 1'b1);
    chk(e, 8'h10);
    {g, k} = 9'h114;
    repeat (5) @(negedge c);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, wk}, 8'h01);
    chk(f, 8'h14);
    io(8'h9d, 8'h00, 1'b1);
    chk({7'h00, irq}, 8'h00);
    io(8'h9d, 8'h10, 1'b1);
    k = 8'h00;
    repeat (5) @(negedge c);
    chk({7'h00, wk}, 8'h00);
    io(8'h9e, 8'h14, 1'b0);
    io(8'h9e, 8'h00, 1'b0);
    io(8'h55, 8'h00, 1'b0);
    io(8'h9c, 8'hff, 1'b1);
    repeat (5) @(negedge c);
    io(8'h9e, 8'hff, 1'b0);
    io(8'h9c, 8'hff, 1'b0);
    g = 1'b0;
    repeat (5) @(negedge c);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, wk}, 8'h01);
    end_sim;
  end
  initial begin
    #100000 miscompares++;
    end_sim;
  end
endmodule // kplif_top_bench
